// ===== verilog/gpt_pkg.sv
// Purpose: Constants and field layouts for the dual group timer unit.
// Assumes: APB register bus, 32-bit data, one aligned word per register.
// Notes: Timer index 0..4 is aux_timer_a, core_timer, aux_timer_b,
//        capture_base_timer, fast_core_timer.
// Summary of operation
// - Five 16-bit timers, groups of three and two
// - Timers chain within group or run alone
// - First-group modes: timer, gated, counter, incremental
// - Timer mode counts prescaled system clock ticks
// - Counter mode counts edges on input pin
// - Gated mode counts only while gate permits
// - First group finest tick is 4 clocks
// - Direction from software or direction pin level
// - Incremental mode decodes quadrature A and B
// - Core toggle latch flips on over/underflow
// - Core latch drives pin and clocks aux timers
// - Aux timer in capture/reload role stops counting
// - Aux capture latches core count on pin edge
// - Aux reload loads core on pin or latch edge
// - Two aux reloads on opposite edges give PWM
// - Second group finest tick is 2 clocks
// - Second group clocked by prescaler or pins
// - Fast toggle latch clocks base timer, drives pin
// - Fast over/underflow pulse out, reloads from register
// - Capture register latches base timer, optional clear
// - Capture also triggered by core input/direction edges
package gpt_pkg;
    localparam int NUM_TIMERS = 5;
    localparam int IDX_AUX_A = 0;
    localparam int IDX_CORE = 1;
    localparam int IDX_AUX_B = 2;
    localparam int IDX_CBASE = 3;
    localparam int IDX_FAST = 4;
    localparam int FIRST_GROUP_SIZE = 3;
    // Word indices of the registers (byte address is four times this)
    localparam logic [5:0] REG_CTRL_BASE = 6'h00;
    localparam logic [5:0] REG_COUNT_BASE = 6'h08;
    localparam logic [5:0] REG_CAPREG = 6'h10;
    localparam logic [5:0] REG_CAPCFG = 6'h11;
    localparam logic [5:0] REG_FLAGS = 6'h12;
    // Operating modes held in the mode field
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_GATE_LOW = 3'h1;
    localparam logic [2:0] MODE_GATE_HIGH = 3'h2;
    localparam logic [2:0] MODE_COUNTER = 3'h3;
    localparam logic [2:0] MODE_INCREMENTAL = 3'h4;
    localparam logic [2:0] MODE_RELOAD = 3'h5;
    localparam logic [2:0] MODE_CAPTURE = 3'h6;
    // Base tick shift per group: 2^2 = 4 clocks, 2^1 = 2 clocks
    localparam logic [3:0] FIRST_TICK_SHIFT = 4'h2;
    localparam logic [3:0] SECOND_TICK_SHIFT = 4'h1;
    localparam int PRESCALE_BITS = 10;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [5:0] CAPCFG_RESET = 6'h00;
    // Per-timer control word
    typedef struct packed {
        logic spare;
        logic out_en;
        logic [1:0] latch_reload;
        logic chain;
        logic [1:0] edge_sel;
        logic ext_dir;
        logic down;
        logic run;
        logic [2:0] prescale;
        logic [2:0] mode;
    } timer_ctrl_s;
    // Capture register configuration
    typedef struct packed {
        logic fast_reload;
        logic clear_base;
        logic trig_core_dir;
        logic trig_core_in;
        logic [1:0] pin_edge;
    } capture_cfg_s;
endpackage : gpt_pkg

// ===== verilog/dual_group_timer_unit.sv
// Purpose: Five 16-bit timers in two groups with capture/reload support.
// Assumes: All pins asynchronous to clk_sys; APB slave with zero wait states.
// Notes: Write to a count register wins over hardware loads and counting.
`timescale 1ns/1ps
module dual_group_timer_unit (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] timer_input_pin,
    input wire logic [4:0] direction_input_pin,
    input wire logic capture_input_pin,
    output logic core_toggle_output,
    output logic fast_toggle_output,
    output logic fast_overflow_pulse,
    output logic [5:0] request_flags
);
    // Reset release pipeline
    logic [1:0] rst_pipe;
    logic rst_n;
    // Pin synchronisers: stage one, stage two, previous value
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] sync_prev;
    logic [10:0] pins;
    // Registers
    gpt_pkg::timer_ctrl_s ctrl [gpt_pkg::NUM_TIMERS];
    logic [15:0] cnt [gpt_pkg::NUM_TIMERS];
    logic [15:0] capreg;
    gpt_pkg::capture_cfg_s capcfg;
    logic [5:0] flags;
    logic core_latch;
    logic fast_latch;
    logic [gpt_pkg::PRESCALE_BITS-1:0] pre;
    // Per-timer working signals
    logic [4:0] count_en;
    logic [4:0] ovf;
    logic [4:0] load;
    logic [4:0] reload_req;
    logic [4:0] capture_req;
    logic [15:0] load_val [gpt_pkg::NUM_TIMERS];
    logic core_rise;
    logic core_fall;
    logic fast_rise;
    logic fast_fall;
    logic cap_trig;
    // Bus decode
    logic [5:0] widx;
    logic wr;
    logic mapped;
    logic [31:0] next_prdata;

    // Reset is asserted at once and released through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    assign pins = {capture_input_pin, direction_input_pin, timer_input_pin};

    // Two-flop synchronisers plus a history stage for edge detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 11'h000;
            sync2 <= 11'h000;
            sync_prev <= 11'h000;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    // Free running prescaler shared by both groups
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre <= '0;
        end else begin
            pre <= pre + 10'h001;
        end
    end

    // Toggle latch transitions, seen in the cycle of the over/underflow
    assign core_rise = ovf[gpt_pkg::IDX_CORE] & ~core_latch;
    assign core_fall = ovf[gpt_pkg::IDX_CORE] & core_latch;
    assign fast_rise = ovf[gpt_pkg::IDX_FAST] & ~fast_latch;
    assign fast_fall = ovf[gpt_pkg::IDX_FAST] & fast_latch;

    // Toggle latches flip on each over/underflow
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_latch <= 1'b0;
            fast_latch <= 1'b0;
        end else begin
            core_latch <= core_latch ^ ovf[gpt_pkg::IDX_CORE];
            fast_latch <= fast_latch ^ ovf[gpt_pkg::IDX_FAST];
        end
    end

    // Latch states to pins when enabled; fast overflow as a pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_toggle_output <= 1'b0;
            fast_toggle_output <= 1'b0;
            fast_overflow_pulse <= 1'b0;
        end else begin
            core_toggle_output <= core_latch & ctrl[gpt_pkg::IDX_CORE].out_en;
            fast_toggle_output <= fast_latch & ctrl[gpt_pkg::IDX_FAST].out_en;
            fast_overflow_pulse <= ovf[gpt_pkg::IDX_FAST];
        end
    end

    // Capture trigger: capture pin edge, or core input/direction edges
    always_comb begin
        cap_trig = (capcfg.pin_edge[0] & sync2[10] & ~sync_prev[10]) |
                   (capcfg.pin_edge[1] & ~sync2[10] & sync_prev[10]);
        if (capcfg.trig_core_in &&
            (sync2[gpt_pkg::IDX_CORE] != sync_prev[gpt_pkg::IDX_CORE])) begin
            cap_trig = 1'b1;
        end
        if (capcfg.trig_core_dir && (sync2[6] != sync_prev[6])) begin
            cap_trig = 1'b1;
        end
    end

    // Per-timer counting engine for all five timers; tick, chain, role and load sources differ per timer
    genvar gi;
    generate
        for (gi = 0; gi < gpt_pkg::NUM_TIMERS; gi++) begin : g_timer
            localparam bit FIRST = (gi < gpt_pkg::FIRST_GROUP_SIZE);
            localparam bit AUX = (gi == gpt_pkg::IDX_AUX_A) || (gi == gpt_pkg::IDX_AUX_B);
            logic [3:0] shift;
            logic [gpt_pkg::PRESCALE_BITS-1:0] mask;
            logic tick;
            logic a_lvl;
            logic a_rise;
            logic a_fall;
            logic b_edge;
            logic a_sel;
            logic chain_edge;
            logic ext_event;
            logic quad_up;
            logic active;
            logic down;
            // Finest tick: 4 clocks in first group, 2 in second
            assign shift = {1'b0, ctrl[gi].prescale} +
                (FIRST ? gpt_pkg::FIRST_TICK_SHIFT : gpt_pkg::SECOND_TICK_SHIFT);
            assign mask = ~(10'h3ff << shift);
            assign tick = ((pre & mask) == mask);
            assign a_lvl = sync2[gi];
            assign a_rise = sync2[gi] & ~sync_prev[gi];
            assign a_fall = ~sync2[gi] & sync_prev[gi];
            assign b_edge = sync2[gi+5] != sync_prev[gi+5];
            assign a_sel = (ctrl[gi].edge_sel[0] & a_rise) | (ctrl[gi].edge_sel[1] & a_fall);
            // Concatenation source: core latch for aux, fast latch for base
            if (AUX) begin : g_chain_core
                assign chain_edge = (ctrl[gi].edge_sel[0] & core_rise) |
                                    (ctrl[gi].edge_sel[1] & core_fall);
            end else if (gi == gpt_pkg::IDX_CBASE) begin : g_chain_fast
                assign chain_edge = (ctrl[gi].edge_sel[0] & fast_rise) |
                                    (ctrl[gi].edge_sel[1] & fast_fall);
            end else begin : g_chain_none
                assign chain_edge = 1'b0;
            end
            assign ext_event = ctrl[gi].chain ? chain_edge : a_sel;
            // Quadrature: up when A now differs from B before
            assign quad_up = sync2[gi] ^ sync_prev[gi+5];
            // Mode selects what advances the count
            always_comb begin
                case (ctrl[gi].mode)
                    gpt_pkg::MODE_TIMER: active = tick;
                    gpt_pkg::MODE_GATE_LOW: active = tick & ~a_lvl;
                    gpt_pkg::MODE_GATE_HIGH: active = tick & a_lvl;
                    gpt_pkg::MODE_COUNTER: active = ext_event;
                    gpt_pkg::MODE_INCREMENTAL: active = FIRST & (a_rise | a_fall | b_edge);
                    default: active = 1'b0;
                endcase
            end
            assign count_en[gi] = ctrl[gi].run & active;
            assign down = (ctrl[gi].mode == gpt_pkg::MODE_INCREMENTAL) ? ~quad_up :
                          (ctrl[gi].down ^ (ctrl[gi].ext_dir & sync2[gi+5]));
            assign ovf[gi] = count_en[gi] &
                (down ? (cnt[gi] == 16'h0000) : (cnt[gi] == gpt_pkg::COUNT_MAX));
            // Aux roles: reload the core timer, or capture it
            if (AUX) begin : g_role
                assign reload_req[gi] = (ctrl[gi].mode == gpt_pkg::MODE_RELOAD) &
                    (a_sel | (ctrl[gi].latch_reload[0] & core_rise) |
                     (ctrl[gi].latch_reload[1] & core_fall));
                assign capture_req[gi] = (ctrl[gi].mode == gpt_pkg::MODE_CAPTURE) & a_sel;
            end else begin : g_norole
                assign reload_req[gi] = 1'b0;
                assign capture_req[gi] = 1'b0;
            end
            // Hardware load source for this timer
            if (gi == gpt_pkg::IDX_CORE) begin : g_load_core
                assign load[gi] = reload_req[gpt_pkg::IDX_AUX_A] | reload_req[gpt_pkg::IDX_AUX_B];
                assign load_val[gi] = reload_req[gpt_pkg::IDX_AUX_A] ?
                    cnt[gpt_pkg::IDX_AUX_A] : cnt[gpt_pkg::IDX_AUX_B];
            end else if (gi == gpt_pkg::IDX_CBASE) begin : g_load_base
                assign load[gi] = cap_trig & capcfg.clear_base;
                assign load_val[gi] = 16'h0000;
            end else if (gi == gpt_pkg::IDX_FAST) begin : g_load_fast
                assign load[gi] = ovf[gi] & capcfg.fast_reload;
                assign load_val[gi] = capreg;
            end else begin : g_load_aux
                assign load[gi] = capture_req[gi];
                assign load_val[gi] = cnt[gpt_pkg::IDX_CORE];
            end
            // Count register: bus write, then load, then count
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cnt[gi] <= gpt_pkg::COUNT_RESET;
                end else if (wr && widx == gpt_pkg::REG_COUNT_BASE + 6'(gi)) begin
                    cnt[gi] <= pwdata[15:0];
                end else if (load[gi]) begin
                    cnt[gi] <= load_val[gi];
                end else if (count_en[gi]) begin
                    cnt[gi] <= down ? cnt[gi] - 16'h0001 : cnt[gi] + 16'h0001;
                end
            end
            // Control register write
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl[gi] <= gpt_pkg::CTRL_RESET;
                end else if (wr && widx == gpt_pkg::REG_CTRL_BASE + 6'(gi)) begin
                    ctrl[gi] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    // Capture/reload register: hardware capture, or bus write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            capreg <= gpt_pkg::COUNT_RESET;
        end else if (cap_trig) begin
            capreg <= cnt[gpt_pkg::IDX_CBASE];
        end else if (wr && widx == gpt_pkg::REG_CAPREG) begin
            capreg <= pwdata[15:0];
        end
    end

    // Capture configuration register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            capcfg <= gpt_pkg::CAPCFG_RESET;
        end else if (wr && widx == gpt_pkg::REG_CAPCFG) begin
            capcfg <= pwdata[5:0];
        end
    end

    // Request flags: write one to clear, a new event wins over the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 6'h00;
        end else begin
            flags <= (flags & ~((wr && widx == gpt_pkg::REG_FLAGS) ? pwdata[5:0] : 6'h00))
                     | {cap_trig, ovf};
        end
    end
    assign request_flags = flags;

    // APB decode; zero wait states
    assign widx = paddr[7:2];
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign mapped = (widx < gpt_pkg::REG_CTRL_BASE + 6'h05) ||
                    (widx >= gpt_pkg::REG_COUNT_BASE && widx < gpt_pkg::REG_COUNT_BASE + 6'h05) ||
                    (widx == gpt_pkg::REG_CAPREG) || (widx == gpt_pkg::REG_CAPCFG) ||
                    (widx == gpt_pkg::REG_FLAGS);
    assign pslverr = psel & penable & ~mapped;

    // Read mux; unmapped reads return zero
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (widx < gpt_pkg::REG_CTRL_BASE + 6'h05) begin
            next_prdata = {16'h0000, ctrl[3'(widx)]};
        end else if (widx >= gpt_pkg::REG_COUNT_BASE &&
                     widx < gpt_pkg::REG_COUNT_BASE + 6'h05) begin
            next_prdata = {16'h0000, cnt[3'(widx - gpt_pkg::REG_COUNT_BASE)]};
        end else if (widx == gpt_pkg::REG_CAPREG) begin
            next_prdata = {16'h0000, capreg};
        end else if (widx == gpt_pkg::REG_CAPCFG) begin
            next_prdata = {26'h0000000, capcfg};
        end else if (widx == gpt_pkg::REG_FLAGS) begin
            next_prdata = {24'h000000, core_latch, fast_latch, flags};
        end
    end

    // Read data captured in the setup cycle, valid through the access phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule : dual_group_timer_unit

// ===== tb/dual_group_timer_unit_props.sv
// Purpose: Port-level checks for the dual group timer unit.
// Assumes: Zero-wait APB slave, one clock domain.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/1ps
module dual_group_timer_unit_props (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [4:0] timer_input_pin,
    input wire logic [4:0] direction_input_pin,
    input wire logic capture_input_pin,
    input wire logic core_toggle_output,
    input wire logic fast_toggle_output,
    input wire logic fast_overflow_pulse,
    input wire logic [5:0] request_flags
);
    localparam logic [7:0] FLAGS_ADDR = {gpt_pkg::REG_FLAGS, 2'b00}; // Flag register
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // True for a word address that holds a register
    function automatic logic mapped(input logic [7:0] a);
        logic [5:0] w;
        w = a[7:2];
        return (w < 6'h05) || (w >= gpt_pkg::REG_COUNT_BASE && w < 6'h0d) ||
            (w >= gpt_pkg::REG_CAPREG && w <= gpt_pkg::REG_FLAGS);
    endfunction : mapped
    // Access phase of a transfer
    sequence s_access;
        psel && penable;
    endsequence
    property p_ready;
        pready;
    endproperty
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    property p_err_unmapped;
        s_access ##0 !mapped(paddr) |-> pslverr;
    endproperty
    property p_ok_mapped;
        s_access ##0 mapped(paddr) |-> !pslverr;
    endproperty
    property p_rdata_hold;
        $changed(prdata) |-> $past(psel && !penable && !pwrite);
    endproperty
    property p_pulse_one;
        $rose(fast_overflow_pulse) |=> !fast_overflow_pulse;
    endproperty
    property p_pulse_flag;
        $rose(fast_overflow_pulse) |-> ##[0:2] request_flags[gpt_pkg::IDX_FAST];
    endproperty
    property p_flag_sticky;
        |($past(request_flags) & ~request_flags) |->
            $past(psel && penable && pwrite && paddr == FLAGS_ADDR);
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr on hole");
    a_ok_mapped: assert property (p_ok_mapped) else $error("pslverr on register");
    a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved");
    a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
    a_pulse_flag: assert property (p_pulse_flag) else $error("no fast flag");
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
endmodule : dual_group_timer_unit_props

// ===== tb/pin_source_model.sv
// Purpose: Drives timer, direction and capture pins as outside parts do.
// Assumes: Pins are levels, each held several clocks.
// Notes: Changes land just after a rising edge.
`timescale 1ns/1ps
module pin_source_model (
    input wire logic clk_sys,
    output logic [4:0] tin,
    output logic [4:0] tdir,
    output logic cap
);
    // Idle levels at time zero
    initial begin
        tin = 5'h00;
        tdir = 5'h00;
        cap = 1'b0;
    end
    // Set one pin pair, held past the synchronisers
    task automatic level(input int i, input logic a, input logic b);
        @(posedge clk_sys);
        tin[i] <= a;
        tdir[i] <= b;
        repeat (3) @(posedge clk_sys);
    endtask : level
    // One high pulse on a timer input pin
    task automatic pulse(input int i);
        level(i, 1'b1, tdir[i]);
        level(i, 1'b0, tdir[i]);
    endtask : pulse
    // One high pulse on the capture pin
    task automatic cap_pulse;
        @(posedge clk_sys);
        cap <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cap <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : cap_pulse
    // Gray steps of a quadrature sensor; forward counts up
    task automatic quad(input int i, input int n, input logic up);
        logic a;
        logic b;
        for (int k = 0; k < n; k++) begin
            a = tin[i];
            b = tdir[i];
            // Forward toggles A when A equals B
            if ((a == b) == up) begin
                a = ~a;
            end else begin
                b = ~b;
            end
            level(i, a, b);
        end
    endtask : quad
endmodule : pin_source_model

// ===== tb/test_dual_group_timer_unit.sv
// Purpose: Self-checking bench for the dual group timer unit.
// Assumes: Zero-wait APB slave; pins come from pin_source_model.
// Notes: Tick rates are measured as count differences over 80 clocks.
`timescale 1ns/1ps
module test_dual_group_timer_unit;
    logic clk_sys = 1'b0; // System clock
    logic resetn = 1'b0; // Active-low reset
    logic psel = 1'b0; // APB request lines
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata; // Read data and answer
    logic pready;
    logic pslverr;
    logic [31:0] rdata; // Last read result
    logic err; // Last error answer
    logic [15:0] v0; // First count of a window
    logic [4:0] tin; // Pin lines from the model
    logic [4:0] tdir;
    logic cap;
    logic core_toggle_output;
    logic fast_toggle_output;
    logic fast_overflow_pulse;
    logic [5:0] request_flags;
    int error_cnt = 0; // Mismatches
    int n_tests = 0; // Comparisons
    int cyc = 0; // Cycle count for the hang limit
    // Clock at 25 MHz
    always #20 clk_sys = ~clk_sys;
    dual_group_timer_unit dual_group_timer_unit_i (.clk_sys(clk_sys), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(tin),
        .direction_input_pin(tdir), .capture_input_pin(cap),
        .core_toggle_output(core_toggle_output), .fast_toggle_output(fast_toggle_output),
        .fast_overflow_pulse(fast_overflow_pulse), .request_flags(request_flags));
    pin_source_model pin_source_model_i (.clk_sys(clk_sys), .tin(tin), .tdir(tdir), .cap(cap));
    // Verdict and end of run
    task automatic end_sim;
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    // Compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Byte address of a word
    function automatic logic [7:0] ra(input logic [5:0] w);
        return {w, 2'b00};
    endfunction : ra
    function automatic logic [7:0] ctl(input int i);
        return ra(gpt_pkg::REG_CTRL_BASE + 6'(i));
    endfunction : ctl
    function automatic logic [7:0] cnt(input int i);
        return ra(gpt_pkg::REG_COUNT_BASE + 6'(i));
    endfunction : cnt
    // Read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask : rd_chk
    // Run a timer with a control word, compare ticks over 80 clocks
    task automatic rate(input int i, input logic [15:0] c, input logic dn, input logic [31:0] e);
        apb(1'b1, ctl(i), {16'h0, c});
        apb(1'b0, cnt(i), 32'h0);
        v0 = rdata[15:0];
        repeat (77) @(posedge clk_sys);
        apb(1'b0, cnt(i), 32'h0);
        check({16'h0, dn ? v0 - rdata[15:0] : rdata[15:0] - v0}, e);
        apb(1'b1, ctl(i), 32'h0);
    endtask : rate
    // Hang limit
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            rd_chk(ctl(i), 32'h0);
            rd_chk(cnt(i), 32'h0);
        end
        rd_chk(ra(gpt_pkg::REG_CAPCFG), 32'h0);
        rd_chk(ra(gpt_pkg::REG_FLAGS), 32'h0);
        apb(1'b1, 8'hfc, 32'h1);
        check({31'h0, err}, 32'h1);
        rd_chk(8'hfc, 32'h0);
        rate(0, 16'h00c0, 1'b1, 32'd20);
        rate(1, 16'h0048, 1'b0, 32'd10);
        rate(2, 16'h0050, 1'b0, 32'd5);
        rate(3, 16'h0040, 1'b0, 32'd40);
        rate(4, 16'h0048, 1'b0, 32'd20);
        // Counter mode, then direction from the pin
        apb(1'b1, cnt(2), 32'h0);
        apb(1'b1, ctl(2), 32'h0243);
        repeat (5) pin_source_model_i.pulse(2);
        rd_chk(cnt(2), 32'h5);
        pin_source_model_i.level(2, 1'b0, 1'b1);
        apb(1'b1, ctl(2), 32'h0343);
        repeat (3) pin_source_model_i.pulse(2);
        rd_chk(cnt(2), 32'h2);
        apb(1'b1, ctl(2), 32'h0);
        // Gated mode, gate shut then open
        rate(0, 16'h0042, 1'b0, 32'd0);
        pin_source_model_i.level(0, 1'b1, 1'b0);
        rate(0, 16'h0041, 1'b0, 32'd0);
        rate(0, 16'h0042, 1'b0, 32'd20);
        // Quadrature decoding
        apb(1'b1, cnt(1), 32'h0);
        apb(1'b1, ctl(1), 32'h0044);
        pin_source_model_i.quad(1, 8, 1'b1);
        pin_source_model_i.quad(1, 3, 1'b0);
        rd_chk(cnt(1), 32'h5);
        apb(1'b1, ctl(1), 32'h0);
        // Aux capture of the stopped core count
        apb(1'b1, cnt(1), 32'h1234);
        apb(1'b1, ctl(2), 32'h0246);
        pin_source_model_i.pulse(2);
        repeat (40) @(posedge clk_sys);
        rd_chk(cnt(2), 32'h1234);
        // Aux reload of the core
        pin_source_model_i.level(0, 1'b0, 1'b0);
        apb(1'b1, ctl(0), 32'h0245);
        apb(1'b1, cnt(0), 32'h0abc);
        pin_source_model_i.pulse(0);
        rd_chk(cnt(1), 32'h0abc);
        rd_chk(cnt(0), 32'h0abc);
        // Capture register from the pin, with clear
        apb(1'b1, ra(gpt_pkg::REG_FLAGS), 32'h3f);
        apb(1'b1, cnt(3), 32'h55);
        apb(1'b1, ra(gpt_pkg::REG_CAPCFG), 32'h11);
        pin_source_model_i.cap_pulse();
        rd_chk(ra(gpt_pkg::REG_CAPREG), 32'h55);
        rd_chk(cnt(3), 32'h0);
        rd_chk(ra(gpt_pkg::REG_FLAGS), 32'h20);
        apb(1'b1, ra(gpt_pkg::REG_CAPCFG), 32'h04);
        apb(1'b1, cnt(3), 32'h77);
        pin_source_model_i.pulse(1);
        rd_chk(ra(gpt_pkg::REG_CAPREG), 32'h77);
        // Overflow of core and fast timers, toggles and reload
        apb(1'b1, ra(gpt_pkg::REG_FLAGS), 32'h3f);
        apb(1'b1, ra(gpt_pkg::REG_CAPCFG), 32'h20);
        apb(1'b1, ra(gpt_pkg::REG_CAPREG), 32'h1000);
        apb(1'b1, cnt(1), 32'hfffe);
        apb(1'b1, cnt(4), 32'hfffe);
        apb(1'b1, ctl(2), 32'h0a43);
        apb(1'b1, ctl(1), 32'h4040);
        apb(1'b1, ctl(4), 32'h4040);
        repeat (30) @(posedge clk_sys);
        @(negedge clk_sys);
        check({30'h0, core_toggle_output, fast_toggle_output}, 32'h3);
        rd_chk(ra(gpt_pkg::REG_FLAGS), 32'hd2);
        apb(1'b1, ra(gpt_pkg::REG_FLAGS), 32'h12);
        rd_chk(ra(gpt_pkg::REG_FLAGS), 32'hc0);
        rd_chk(cnt(2), 32'h1235);
        apb(1'b1, ctl(4), 32'h0);
        apb(1'b0, cnt(4), 32'h0);
        check({8'h0, rdata[31:8]}, 32'h10);
        end_sim();
    end
endmodule : test_dual_group_timer_unit
bind dual_group_timer_unit dual_group_timer_unit_props props_i (.clk_sys(clk_sys),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_pin(timer_input_pin), .direction_input_pin(direction_input_pin),
    .capture_input_pin(capture_input_pin), .core_toggle_output(core_toggle_output),
    .fast_toggle_output(fast_toggle_output), .fast_overflow_pulse(fast_overflow_pulse),
    .request_flags(request_flags));
